// ==== logic/apcpe_bclk_div.sv ====
// Bit clock divider: fractional accumulator on the core clock
// Assumes the divider code is never a reserved one
module apcpe_bclk_div (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       enable,
  input  wire logic [4:0] divider_sel,
  output logic            level,
  output logic            rise
);
  logic [8:0] ratio_q;
  logic [8:0] acc_q;
  logic [8:0] acc_sum;
  logic [8:0] acc_d;
  logic       wrap;

  always_comb begin
    acc_sum = 9'(acc_q + 9'h002);
    wrap    = acc_sum >= ratio_q;
    acc_d   = wrap ? 9'(acc_sum - ratio_q) : acc_sum;
  end

  // New ratio is taken every cycle while disabled, and while running only at a period boundary
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ratio_q <= 9'h008;
      acc_q   <= 9'h000;
      level   <= 1'b0;
      rise    <= 1'b0;
    end else if (!enable) begin
      ratio_q <= apcpe_pkg::bclk_half_ratio(divider_sel);
      acc_q   <= 9'h000;
      level   <= 1'b0;
      rise    <= 1'b0;
    end else begin
      if (wrap) begin
        ratio_q <= apcpe_pkg::bclk_half_ratio(divider_sel); // R18
      end
      acc_q <= acc_d; // R06
      level <= acc_d < (ratio_q >> 1);
      rise  <= wrap;
    end
  end
endmodule

// ==== logic/apcpe_frame_div.sv ====
// Frame clock divider counting bit clock ticks
// Assumes tick is a one-cycle pulse per bit clock period
module apcpe_frame_div (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        enable,
  input  wire logic        tick,
  input  wire logic        dsp,
  input  wire logic [10:0] rate,
  output logic             level,
  output logic             start
);
  logic [10:0] cnt_q;
  logic [10:0] ratio_q;
  logic [10:0] cnt_inc;
  logic [10:0] rate_ok;

  always_comb begin
    cnt_inc = 11'(cnt_q + 11'h001);
    rate_ok = (rate < apcpe_pkg::RATE_MIN) ? apcpe_pkg::RATE_MIN : rate;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q   <= 11'h000;
      ratio_q <= apcpe_pkg::RATE_RESET;
      level   <= 1'b0;
      start   <= 1'b0;
    end else if (!enable) begin
      cnt_q   <= 11'h000;
      ratio_q <= rate_ok;
      level   <= 1'b0;
      start   <= 1'b0;
    end else begin
      start <= 1'b0;
      if (tick) begin
        if (cnt_inc >= ratio_q) begin
          cnt_q   <= 11'h000; // R08
          ratio_q <= rate_ok; // R18
          start   <= 1'b1;
          level   <= 1'b1;
        end else begin
          cnt_q <= cnt_inc;
          level <= dsp ? 1'b0 : (cnt_inc < (ratio_q >> 1));
        end
      end
    end
  end
endmodule

// ==== logic/apcpe_pkg.sv ====
// Constants for the second audio port clock generation and path enables
// Assumes 16-bit registers reached over a plain strobe port
package apcpe_pkg;
  localparam logic [15:0] ADDR_PWR_TX   = 16'h0004;
  localparam logic [15:0] ADDR_PWR_RX   = 16'h0005;
  localparam logic [15:0] ADDR_PORT_CTL = 16'h0310;
  localparam logic [15:0] ADDR_MODE     = 16'h0312;
  localparam logic [15:0] ADDR_BCLK     = 16'h0313;
  localparam logic [15:0] ADDR_FRAME    = 16'h0315;
  localparam logic [15:0] ADDR_TX_SLOT  = 16'h0318;
  localparam logic [15:0] ADDR_STATUS   = 16'h0320;

  localparam int LEFT_PATH_BIT  = 13;
  localparam int RIGHT_PATH_BIT = 12;
  localparam int LEFT_SLOT_BIT  = 1;
  localparam int RIGHT_SLOT_BIT = 0;
  localparam int BCLK_INV_BIT   = 8;
  localparam int FMT_LSB        = 3;
  localparam int MASTER_BIT     = 14;
  localparam int DIV_LSB        = 4;
  localparam int FRAME_INV_BIT  = 12;
  localparam int FRAME_DIR_BIT  = 11;

  localparam logic [1:0]  PATH_RESET = 2'h0;
  localparam logic [1:0]  SLOT_RESET = 2'h3;
  localparam logic [1:0]  FMT_RESET  = 2'h2;
  localparam logic [1:0]  FMT_I2S    = 2'h2;
  localparam logic [1:0]  FMT_DSP    = 2'h3;
  localparam logic [4:0]  DIV_RESET  = 5'h04;
  localparam logic [4:0]  DIV_LAST   = 5'h15;
  localparam logic [10:0] RATE_RESET = 11'h040;
  localparam logic [10:0] RATE_MIN   = 11'h008;
  localparam int          RX_WORD_W  = 32;

  // Bit clock period in half core clock cycles for each divider code
  function automatic logic [8:0] bclk_half_ratio(input logic [4:0] sel);
    case (sel)
      5'h00: bclk_half_ratio = 9'h002;
      5'h01: bclk_half_ratio = 9'h003;
      5'h02: bclk_half_ratio = 9'h004;
      5'h03: bclk_half_ratio = 9'h006;
      5'h04: bclk_half_ratio = 9'h008;
      5'h05: bclk_half_ratio = 9'h00a;
      5'h06: bclk_half_ratio = 9'h00c;
      5'h07: bclk_half_ratio = 9'h010;
      5'h08: bclk_half_ratio = 9'h016;
      5'h09: bclk_half_ratio = 9'h018;
      5'h0a: bclk_half_ratio = 9'h020;
      5'h0b: bclk_half_ratio = 9'h02c;
      5'h0c: bclk_half_ratio = 9'h030;
      5'h0d: bclk_half_ratio = 9'h040;
      5'h0e: bclk_half_ratio = 9'h058;
      5'h0f: bclk_half_ratio = 9'h060;
      5'h10: bclk_half_ratio = 9'h080;
      5'h11: bclk_half_ratio = 9'h0b0;
      5'h12: bclk_half_ratio = 9'h0c0;
      5'h13: bclk_half_ratio = 9'h100;
      5'h14: bclk_half_ratio = 9'h160;
      default: bclk_half_ratio = 9'h180;
    endcase
  endfunction
endpackage

// ==== logic/apcpe_port.sv ====
// Second audio port: path enables, bit and frame clock generation, rx capture
// Assumes synchronous pin inputs and a strobe register port, data one cycle late
//
// Overview of operation
// R01 - Left transmit path enable, power register four bit 13, reset 0.
// R02 - Right transmit path enable, power register four bit 12, reset 0.
// R03 - Left and right receive path enables, power register five bits 13, 12.
// R04 - Transmit-slot enables bits 1 and 0, reset 1, gate sending on this port.
// R05 - Cleared slot enables do not block routing to the third port.
// R06 - Bit clock is core clock divided by field 8:4, reset divide by four.
// R07 - Divider codes give ratios 1 to 192; codes 10110 and up are reserved.
// R08 - Frame clock is bit clock divided by 11-bit rate, reset 040h, 8 to 2047.
// R09 - One frame clock serves both directions, so both share one sample rate.
// R10 - Master mode drives the frame clock while any channel is enabled.
// R11 - Slave mode leaves frame pin undriven unless the direction bit forces it.
// R12 - Bit clock inversion bit 8 applies in master and slave modes.
// R13 - Slave receive data sampled on rising bit clock, falling when inverted.
// R14 - Non-DSP formats: frame bit 12 inverts frame clock polarity.
// R15 - DSP format: frame bit 12 picks mode A (second edge) or B (first edge).
// R16 - Master select bit: slave at 0, master at 1 generating both clocks.
// R17 - Format field bits 4:3 picks right, left, I2S or DSP (11).
// R18 - Divider ratios change only at a divided clock boundary.
module apcpe_port (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        bclk_in,
  output logic             bclk_out,
  output logic             bclk_oe,
  input  wire logic        frame_in,
  output logic             frame_out,
  output logic             frame_oe,
  input  wire logic        rx_serial_data,
  output logic             left_tx_port_on,
  output logic             right_tx_port_on,
  output logic             left_tx_third_on,
  output logic             right_tx_third_on,
  output logic             left_rx_on,
  output logic             right_rx_on,
  output logic      [31:0] rx_data,
  output logic             rx_msb_strobe
);
  logic [1:0]  tx_path_q;
  logic [1:0]  rx_path_q;
  logic [1:0]  tx_slot_q;
  logic        bit_clock_invert_q;
  logic [1:0]  serial_format_sel_q;
  logic        master_select_q;
  logic [4:0]  bit_clock_divider_sel_q;
  logic        frame_clock_invert_q;
  logic        frame_clock_force_drive_q;
  logic [10:0] frame_clock_ratio_q;
  logic        bclk_in_q;
  logic        frame_in_q;
  logic        rxd_q;
  logic        bclk_prev_q;
  logic        frame_prev_q;
  logic        skip_q;
  logic        armed_q;
  logic        any_ch;
  logic        dsp;
  logic        bclk_drive;
  logic        frame_drive;
  logic        div_level;
  logic        div_rise;
  logic        frm_level;
  logic        frm_start;
  logic        bclk_true;
  logic        frame_true;
  logic        bit_tick;
  logic        frame_rise;
  logic        lead_skip;
  logic        wr_div;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_path_q <= apcpe_pkg::PATH_RESET;
      rx_path_q <= apcpe_pkg::PATH_RESET;
    end else if (reg_wr && reg_addr == apcpe_pkg::ADDR_PWR_TX) begin
      tx_path_q <= {reg_wdata[apcpe_pkg::LEFT_PATH_BIT],
                    reg_wdata[apcpe_pkg::RIGHT_PATH_BIT]}; // R01 R02
    end else if (reg_wr && reg_addr == apcpe_pkg::ADDR_PWR_RX) begin
      rx_path_q <= {reg_wdata[apcpe_pkg::LEFT_PATH_BIT],
                    reg_wdata[apcpe_pkg::RIGHT_PATH_BIT]}; // R03
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_slot_q <= apcpe_pkg::SLOT_RESET;
    end else if (reg_wr && reg_addr == apcpe_pkg::ADDR_TX_SLOT) begin
      tx_slot_q <= {reg_wdata[apcpe_pkg::LEFT_SLOT_BIT],
                    reg_wdata[apcpe_pkg::RIGHT_SLOT_BIT]}; // R04
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_clock_invert_q  <= 1'b0;
      serial_format_sel_q <= apcpe_pkg::FMT_RESET;
      master_select_q     <= 1'b0;
    end else if (reg_wr && reg_addr == apcpe_pkg::ADDR_PORT_CTL) begin
      bit_clock_invert_q  <= reg_wdata[apcpe_pkg::BCLK_INV_BIT]; // R12
      serial_format_sel_q <= reg_wdata[apcpe_pkg::FMT_LSB +: 2]; // R17
    end else if (reg_wr && reg_addr == apcpe_pkg::ADDR_MODE) begin
      master_select_q <= reg_wdata[apcpe_pkg::MASTER_BIT]; // R16
    end
  end

  // Reserved divider codes are refused; the previous ratio stays
  assign wr_div = reg_wr && reg_addr == apcpe_pkg::ADDR_BCLK;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_clock_divider_sel_q <= apcpe_pkg::DIV_RESET;
    end else if (wr_div && reg_wdata[apcpe_pkg::DIV_LSB +: 5] <= apcpe_pkg::DIV_LAST) begin
      bit_clock_divider_sel_q <= reg_wdata[apcpe_pkg::DIV_LSB +: 5]; // R07
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      frame_clock_invert_q      <= 1'b0;
      frame_clock_force_drive_q <= 1'b0;
      frame_clock_ratio_q       <= apcpe_pkg::RATE_RESET;
    end else if (reg_wr && reg_addr == apcpe_pkg::ADDR_FRAME) begin
      frame_clock_invert_q      <= reg_wdata[apcpe_pkg::FRAME_INV_BIT]; // R14
      frame_clock_force_drive_q <= reg_wdata[apcpe_pkg::FRAME_DIR_BIT]; // R11
      frame_clock_ratio_q       <= reg_wdata[10:0]; // R08
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        apcpe_pkg::ADDR_PWR_TX:   reg_rdata <= {2'h0, tx_path_q, 12'h000};
        apcpe_pkg::ADDR_PWR_RX:   reg_rdata <= {2'h0, rx_path_q, 12'h000};
        apcpe_pkg::ADDR_PORT_CTL: reg_rdata <= {7'h00, bit_clock_invert_q, 3'h0,
                                                serial_format_sel_q, 3'h0};
        apcpe_pkg::ADDR_MODE:     reg_rdata <= {1'b0, master_select_q, 14'h0000};
        apcpe_pkg::ADDR_BCLK:     reg_rdata <= {7'h00, bit_clock_divider_sel_q, 4'h0};
        apcpe_pkg::ADDR_FRAME:    reg_rdata <= {3'h0, frame_clock_invert_q,
                                                frame_clock_force_drive_q,
                                                frame_clock_ratio_q};
        apcpe_pkg::ADDR_TX_SLOT:  reg_rdata <= {14'h0000, tx_slot_q};
        apcpe_pkg::ADDR_STATUS:   reg_rdata <= {12'h000, armed_q, any_ch,
                                                frame_drive, bclk_drive};
        default:                  reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Path enables

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      left_tx_port_on   <= 1'b0;
      right_tx_port_on  <= 1'b0;
      left_tx_third_on  <= 1'b0;
      right_tx_third_on <= 1'b0;
      left_rx_on        <= 1'b0;
      right_rx_on       <= 1'b0;
    end else begin
      left_tx_port_on   <= tx_path_q[1] && tx_slot_q[1]; // R01 R04
      right_tx_port_on  <= tx_path_q[0] && tx_slot_q[0]; // R02 R04
      left_tx_third_on  <= tx_path_q[1]; // R05
      right_tx_third_on <= tx_path_q[0]; // R05
      left_rx_on        <= rx_path_q[1]; // R03
      right_rx_on       <= rx_path_q[0]; // R03
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock generation

  always_comb begin
    any_ch      = (|tx_path_q) || (|rx_path_q);
    dsp         = serial_format_sel_q == apcpe_pkg::FMT_DSP;
    bclk_drive  = master_select_q && any_ch; // R16
    frame_drive = bclk_drive || frame_clock_force_drive_q; // R10 R11
  end

  apcpe_bclk_div u_bclk_div (
    .clock       (clock),
    .resetn      (resetn),
    .enable      (bclk_drive),
    .divider_sel (bit_clock_divider_sel_q),
    .level       (div_level),
    .rise        (div_rise)
  );

  // One frame divider for both directions keeps them at one rate
  apcpe_frame_div u_frame_div (
    .clock  (clock),
    .resetn (resetn),
    .enable (frame_drive),
    .tick   (bit_tick), // R09
    .dsp    (dsp),
    .rate   (frame_clock_ratio_q),
    .level  (frm_level),
    .start  (frm_start)
  );

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bclk_oe   <= 1'b0;
      bclk_out  <= 1'b0;
      frame_oe  <= 1'b0;
      frame_out <= 1'b0;
    end else begin
      bclk_oe   <= bclk_drive;
      bclk_out  <= bclk_drive && (div_level ^ bit_clock_invert_q); // R12
      frame_oe  <= frame_drive; // R10 R11
      frame_out <= frame_drive && (frm_level ^ (frame_clock_invert_q && !dsp)); // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive capture

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bclk_in_q    <= 1'b0;
      frame_in_q   <= 1'b0;
      rxd_q        <= 1'b0;
      bclk_prev_q  <= 1'b0;
      frame_prev_q <= 1'b0;
    end else begin
      bclk_in_q    <= bclk_in;
      frame_in_q   <= frame_in;
      rxd_q        <= rx_serial_data;
      bclk_prev_q  <= bclk_true;
      frame_prev_q <= frame_true;
    end
  end

  always_comb begin
    bclk_true  = master_select_q ? div_level : (bclk_in_q ^ bit_clock_invert_q); // R13
    bit_tick   = master_select_q ? div_rise : (bclk_true && !bclk_prev_q);
    frame_true = frame_drive ? frm_level :
                 (frame_in_q ^ (frame_clock_invert_q && !dsp));
    frame_rise = frame_true && !frame_prev_q;
    lead_skip  = dsp ? !frame_clock_invert_q : // R15
                 (serial_format_sel_q == apcpe_pkg::FMT_I2S);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      skip_q        <= 1'b0;
      armed_q       <= 1'b0;
      rx_data       <= 32'h00000000;
      rx_msb_strobe <= 1'b0;
    end else begin
      rx_msb_strobe <= 1'b0;
      if (frame_rise) begin
        skip_q  <= lead_skip; // R15
        armed_q <= |rx_path_q;
      end else if (bit_tick && skip_q) begin
        skip_q <= 1'b0;
      end else if (bit_tick) begin
        rx_data <= {rx_data[30:0], rxd_q}; // R13
        if (armed_q) begin
          rx_msb_strobe <= 1'b1;
          armed_q       <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_left_tx_gate: assert property ( // R01
    (reg_wr && reg_addr == apcpe_pkg::ADDR_PWR_TX && !reg_wdata[13]) |=> ##1 !left_tx_port_on)
    else $error("left transmit still on after path cleared");
  a_right_tx_third: assert property ( // R02
    (reg_wr && reg_addr == apcpe_pkg::ADDR_PWR_TX && reg_wdata[12]) |=> ##1 right_tx_third_on)
    else $error("right transmit path not routed");
  a_rx_path_on: assert property ( // R03
    (reg_wr && reg_addr == apcpe_pkg::ADDR_PWR_RX) |=> ##1 (left_rx_on == $past(reg_wdata[13], 2)))
    else $error("left receive enable mismatch");
  a_slot_blocks: assert property ( // R04
    (reg_wr && reg_addr == apcpe_pkg::ADDR_TX_SLOT && !reg_wdata[0]) |=> ##1 !right_tx_port_on)
    else $error("right transmit sent with slot cleared");
  a_third_route: assert property ( // R05
    (tx_path_q[1] && !tx_slot_q[1]) |=> (left_tx_third_on && !left_tx_port_on))
    else $error("third port routing blocked by slot");
  a_div_reserved: assert property ( // R07
    (wr_div && reg_wdata[8:4] > 5'h15) |=> $stable(bit_clock_divider_sel_q))
    else $error("reserved divider code accepted");
  a_master_frame: assert property ( // R10
    (master_select_q && any_ch) [*2] |=> (frame_oe && bclk_oe))
    else $error("master not driving clocks");
  a_slave_quiet: assert property ( // R11
    (!master_select_q && !frame_clock_force_drive_q) |=> (!frame_oe && !bclk_oe))
    else $error("slave drives frame pin");
  a_slave_edge: assert property ( // R13
    (!master_select_q && bit_tick) |-> ((bclk_in_q ^ bit_clock_invert_q)
      && !$past(bclk_in_q ^ bit_clock_invert_q)))
    else $error("receive sampled on wrong bit clock edge");
  a_msb_mode: assert property ( // R15
    (frame_rise && dsp && !frame_clock_invert_q) |=> skip_q)
    else $error("mode A does not skip first edge");

  c_master_run: cover property (frame_oe && frm_start);
  c_msb_seen: cover property (rx_msb_strobe && dsp);
  c_mode_b: cover property (frame_rise && dsp && frame_clock_invert_q);
endmodule

// ==== test/apcpe_host_model.sv ====
// Far side audio interface: makes bit clock, frame and receive data
// Assumes the port samples its pins on the same core clock
module apcpe_host_model (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        run,
  input  wire logic        invert,
  input  wire logic        skip,
  input  wire logic [31:0] word,
  output logic             bclk,
  output logic             frame,
  output logic             data
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 2;
  localparam int RATE = 64;
  int   ph;
  int   pos;
  int   nxt;
  int   k;
  logic clk_q;

  assign bclk = clk_q ^ invert;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ph <= 0;
      pos <= RATE - 1;
      clk_q <= 1'b0;
      frame <= 1'b0;
      data <= 1'b0;
    end else if (!run) begin
      // Clock stands still while run is low; released data line keeps changing
      ph <= 0;
      pos <= RATE - 1;
      clk_q <= 1'b0;
      frame <= 1'b0;
      data <= ~data;
    end else if (ph == HALF - 1) begin
      ph <= 0;
      clk_q <= ~clk_q;
      if (clk_q) begin
        // Launch on the falling true edge so the port captures on the rising one
        nxt = (pos + 1) % RATE;
        k = nxt - int'(skip);
        pos <= nxt;
        frame <= (nxt < RATE / 2);
        if (k >= 0 && k < 32) data <= word[31 - k];
        else data <= ~data;
      end
    end else begin
      ph <= ph + 1;
    end
  end
endmodule

// ==== test/apcpe_port_test.sv ====
// Self-checking bench for the second audio port clock and path logic
// Assumes the host model above as far side and a 125 MHz core clock
module apcpe_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock;
  logic        resetn;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        bclk_out, bclk_oe, frame_out, frame_oe, rx_serial_data;
  logic        h_bclk, h_frame, h_run, h_inv, h_skip;
  logic [31:0] h_word;
  logic        ltx, rtx, lth, rth, lrx, rrx, rx_msb_strobe;
  logic [31:0] rx_data;
  int          errors;
  int          cmp_count;

  apcpe_port u_apcpe_port (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bclk_in(bclk_oe ? bclk_out : h_bclk), .bclk_out(bclk_out), .bclk_oe(bclk_oe),
    .frame_in(frame_oe ? frame_out : h_frame), .frame_out(frame_out), .frame_oe(frame_oe),
    .rx_serial_data(rx_serial_data), .left_tx_port_on(ltx), .right_tx_port_on(rtx),
    .left_tx_third_on(lth), .right_tx_third_on(rth), .left_rx_on(lrx), .right_rx_on(rrx),
    .rx_data(rx_data), .rx_msb_strobe(rx_msb_strobe));

  apcpe_host_model u_apcpe_host_model (
    .clock(clock), .resetn(resetn), .run(h_run), .invert(h_inv), .skip(h_skip),
    .word(h_word), .bclk(h_bclk), .frame(h_frame), .data(rx_serial_data));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  // Cycles between two rising edges of the bit clock (sel 0) or frame (sel 1)
  task automatic meas(input bit sel, output int n);
    logic p, c;
    int   t0, t;
    p = 1'b1;
    t0 = -1;
    n = 0;
    for (t = 0; t < 3000 && n == 0; t++) begin
      @(posedge clock);
      #1;
      c = sel ? frame_out : bclk_out;
      if (c === 1'b1 && p === 1'b0) begin
        if (t0 < 0) t0 = t;
        else n = t - t0;
      end
      p = c;
    end
    if (n == 0) begin
      chk("edge timeout", 0, 1);
      wrap_up();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    logic [15:0] a [8] = '{16'h0004, 16'h0005, 16'h0310, 16'h0312, 16'h0313, 16'h0315,
                           16'h0318, 16'h0100};
    logic [15:0] e [8] = '{16'h0000, 16'h0000, 16'h0010, 16'h0000, 16'h0040, 16'h0040,
                           16'h0003, 16'h0000};
    logic [15:0] d;
    for (int i = 0; i < 8; i++) begin
      rd(a[i], d);
      chk("reset value", d, e[i]);
    end
  endtask

  task automatic t_paths();
    wr(apcpe_pkg::ADDR_PWR_TX, 16'h3000);
    wr(apcpe_pkg::ADDR_PWR_RX, 16'h2000);
    wr(apcpe_pkg::ADDR_TX_SLOT, 16'h0002);
    settle();
    chk("tx port on", {ltx, rtx}, 2'h2);
    chk("tx third on", {lth, rth}, 2'h3);
    chk("rx on", {lrx, rrx}, 2'h2);
    wr(apcpe_pkg::ADDR_TX_SLOT, 16'h0000);
    wr(apcpe_pkg::ADDR_PWR_TX, 16'h1000);
    settle();
    chk("tx port off", {ltx, rtx}, 2'h0);
    chk("tx third kept", {lth, rth}, 2'h1);
    wr(apcpe_pkg::ADDR_TX_SLOT, 16'h0003);
  endtask

  task automatic t_master_clocks();
    logic [4:0] c [6] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07};
    int         r [6] = '{2, 3, 4, 5, 6, 8};
    logic [15:0] d;
    int          n, runlen, bad;
    logic        p;
    wr(apcpe_pkg::ADDR_BCLK, 16'h0160);
    wr(apcpe_pkg::ADDR_BCLK, 16'h01f0);
    rd(apcpe_pkg::ADDR_BCLK, d);
    chk("reserved divider", d, 16'h0040);
    wr(apcpe_pkg::ADDR_MODE, 16'h4000);
    settle();
    chk("master drive", {bclk_oe, frame_oe}, 2'h3);
    for (int i = 0; i < 6; i++) begin
      wr(apcpe_pkg::ADDR_BCLK, {7'h00, c[i], 4'h0});
      meas(0, n);
      meas(0, n);
      chk("bit clock period", n, r[i]);
    end
    wr(apcpe_pkg::ADDR_BCLK, 16'h0040);
    wr(apcpe_pkg::ADDR_FRAME, 16'h0008);
    meas(1, n);
    meas(1, n);
    chk("frame period", n, 32);
    wr(apcpe_pkg::ADDR_BCLK, 16'h0070);
    meas(0, n);
    wr(apcpe_pkg::ADDR_BCLK, 16'h0040);
    // Every level run must be a whole old or new half period
    p = bclk_out;
    runlen = -1000;
    bad = 0;
    repeat (80) begin
      @(posedge clock);
      #1;
      if (bclk_out === p) runlen++;
      else begin
        if (runlen > 0 && runlen != 2 && runlen != 4) bad++;
        runlen = 1;
      end
      p = bclk_out;
    end
    chk("runt pulses", bad, 0);
    wr(apcpe_pkg::ADDR_MODE, 16'h0000);
    wr(apcpe_pkg::ADDR_FRAME, 16'h0040);
    settle();
    chk("slave release", {bclk_oe, frame_oe}, 2'h0);
    rd(apcpe_pkg::ADDR_STATUS, d);
    chk("status drive", d[2:0], 3'h4);
  endtask

  task automatic t_slave_receive();
    logic [1:0] f [5] = '{2'h2, 2'h2, 2'h1, 2'h3, 2'h3};
    logic       m [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic       b [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic       s [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    int         t, n;
    wr(apcpe_pkg::ADDR_PWR_RX, 16'h3000);
    for (int i = 0; i < 5; i++) begin
      wr(apcpe_pkg::ADDR_PORT_CTL, {7'h00, b[i], 3'h0, f[i], 3'h0});
      wr(apcpe_pkg::ADDR_FRAME, {3'h0, m[i], 12'h040});
      @(posedge clock);
      h_inv <= b[i];
      h_skip <= s[i];
      h_word <= 32'ha5c3_96e1 ^ (32'h1 << (4 + i));
      h_run <= 1'b1;
      for (t = 0; t < 400 && rx_msb_strobe !== 1'b1; t++) begin
        @(posedge clock);
        #1;
      end
      if (t == 400) begin
        chk("strobe timeout", 0, 1);
        wrap_up();
      end
      chk("first bit", rx_data[0], h_word[31]);
      repeat (124) @(posedge clock);
      #1;
      chk("rx word", rx_data, h_word);
      h_run <= 1'b0;
      repeat (20) @(posedge clock);
    end
    wr(apcpe_pkg::ADDR_FRAME, 16'h0840);
    h_run <= 1'b1;
    settle();
    chk("forced frame", {bclk_oe, frame_oe}, 2'h1);
    meas(1, n);
    meas(1, n);
    chk("slave frame period", n, 256);
    h_run <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    cmp_count = 0;
    resetn = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    h_run = 1'b0;
    h_inv = 1'b0;
    h_skip = 1'b0;
    h_word = 32'h0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    t_reset_values();
    t_paths();
    t_master_clocks();
    t_slave_receive();
    wrap_up();
  end
endmodule
